// *** dv/pdm_board.sv ***
// Board model that gives the pad levels of port D and port E.
`timescale 1ns/1ps
module pdm_board (
  input wire logic [4:0] pad_oe_pd,
  input wire logic [4:0] pad_out_pd,
  input wire logic [4:0] board_pd,
  input wire logic [2:0] pad_oe_pe,
  input wire logic [2:0] pad_out_pe,
  input wire logic [2:0] board_pe,
  output logic [4:0] pad_in_pd,
  output logic [2:0] pad_in_pe
);
  // A driven pad shows the device value, otherwise the board level; select lines go low only on request.
  assign pad_in_pd = (pad_oe_pd & pad_out_pd) | (~pad_oe_pd & board_pd);
  assign pad_in_pe = (pad_oe_pe & pad_out_pe) | (~pad_oe_pe & board_pe);
endmodule : pdm_board

// *** dv/pdm_mux_sva.sv ***
// Checker for the port D/E alternate-function multiplexer.
`timescale 1ns/1ps
module pdm_mux_sva (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [4:0] dir_bits_pd,
  input wire logic [4:0] out_bits_pd,
  input wire logic pullup_disable,
  input wire logic spi_enable,
  input wire logic spi_master,
  input wire logic spi_alt_pins,
  input wire logic clock_output_fuse,
  input wire logic divided_clock_out,
  input wire logic internal_rc_sel,
  input wire logic reset_pin_disable_fuse,
  input wire logic [4:0] pad_in_pd,
  input wire logic [2:0] pad_in_pe,
  input wire logic [4:0] pad_oe_pd,
  input wire logic [4:0] pad_out_pd,
  input wire logic [4:0] pad_pullup_pd,
  input wire logic [2:0] dir_read_pe,
  input wire logic [2:0] port_read_pe,
  input wire logic spi_slave_sel_n,
  input wire logic timer1_capture_in,
  input wire logic crystal_in_pin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Role decodes, qualified by the update enable so a frozen cycle never counts.
  wire sl = clk_en & spi_enable & spi_alt_pins & ~spi_master;
  wire ms = clk_en & spi_enable & spi_alt_pins & spi_master;
  chk_sck_slave_in: assert property (sl |=> !pad_oe_pd[4]) else $error("clock pin driven as slave");
  chk_master_dir_follow: assert property (ms |=> {pad_oe_pd[4], pad_oe_pd[0]} ==
    $past({dir_bits_pd[4], dir_bits_pd[0]})) else $error("master pins ignore direction");
  chk_forced_pullup: assert property (sl |=> pad_pullup_pd[4] ==
    $past(out_bits_pd[4] & ~pullup_disable)) else $error("forced input lost pull-up");
  chk_capture_copy: assert property (clk_en |=> timer1_capture_in == $past(pad_in_pd[4]))
    else $error("capture input wrong");
  chk_select_follow: assert property (sl |=> !pad_oe_pd[3] && spi_slave_sel_n == $past(pad_in_pd[3]))
    else $error("slave select wrong");
  chk_miso_master_in: assert property (ms |=> !pad_oe_pd[2]) else $error("data-in pin driven as master");
  // The clock output must keep running through reset, so this one is never disabled.
  chk_divided_clock_out_fuse: assert property (disable iff (1'b0) clock_output_fuse |->
    pad_oe_pd[1] && pad_out_pd[1] == divided_clock_out) else $error("clock output missing");
  chk_reset_reads_zero: assert property (clk_en && !reset_pin_disable_fuse |=>
    !(dir_read_pe[0] | port_read_pe[0])) else $error("reset pin reads nonzero");
  chk_clock_input: assert property (clk_en && !internal_rc_sel |=> crystal_in_pin == $past(pad_in_pe[1]))
    else $error("clock input wrong");
endmodule : pdm_mux_sva

bind pdm_mux pdm_mux_sva pdm_mux_sva_i (.*);

// *** dv/tb.sv ***
// Self-checking testbench for the port D/E alternate-function multiplexer.
`timescale 1ns/1ps
module tb;
  logic mclk = 0, reset_n = 0, clk_en = 1, pullup_disable = 0, spi_enable = 0, spi_master = 0, spi_alt_pins = 1;
  logic spi_sck_out = 1, spi_mosi_out = 1, spi_miso_out = 1, timer0_compare_a_out = 1, timer0_compare_a_en = 0;
  logic timer1_compare_a_out = 1, timer1_compare_a_en = 0, timer0_compare_b_out = 1, timer0_compare_b_en = 0;
  logic divided_clock_out = 0, clock_output_fuse = 0, crystal_clock_sel = 0, internal_rc_sel = 1;
  logic reset_pin_disable_fuse = 1, spi_slave_sel_n, spi_alt_slave_sel_n, timer1_capture_in, ext_reset_n;
  logic crystal_in_pin;
  logic [4:0] dir_bits_pd = 5'h00, out_bits_pd = 5'h00, board_pd = 5'h1F, pad_in_pd, pad_oe_pd, pad_out_pd;
  logic [4:0] pad_pullup_pd, pin_read_pd;
  logic [2:0] dir_bits_pe = 3'h0, out_bits_pe = 3'h0, board_pe = 3'h7, pad_in_pe, pad_oe_pe, pad_out_pe;
  logic [2:0] pad_pullup_pe, pin_read_pe, dir_read_pe, port_read_pe;
  int miscompares = 0, num_checks = 0, cycles = 0;
  pdm_mux pdm_mux_i (.*);
  pdm_board pdm_board_i (.*);
  initial forever #25 mclk = ~mclk;
  // The divided clock toggles off the sampling edge; a run ceiling cuts any hang short.
  always @(negedge mclk) divided_clock_out <= ~divided_clock_out;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [4:0] act, input logic [4:0] exp);
    num_checks++;
    if (act !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, act, exp);
    end
  endtask : cmp
  // Three falling edges let the registered outputs and the pad loop settle.
  task automatic settle();
    repeat (3) @(negedge mclk);
  endtask : settle
  initial begin
    repeat (20) @(negedge mclk);
    reset_n = 1;
    dir_bits_pd = 5'h15; out_bits_pd = 5'h1B; dir_bits_pe = 3'h3; out_bits_pe = 3'h5;
    settle();
    cmp(pad_oe_pd, 5'h15);
    cmp(pad_out_pd, 5'h11);
    cmp(pad_pullup_pd, 5'h0A);
    cmp(5'(pad_oe_pe), 5'h03);
    cmp(5'(ext_reset_n), 5'h01);
    cmp(5'(pad_pullup_pe), 5'h04);
    cmp(5'(pad_out_pe), 5'h01);
    cmp(pin_read_pd, 5'h1B);
    cmp(5'(pin_read_pe), 5'h05);
    cmp(5'({dir_read_pe, port_read_pe}), 5'h1D);
    $display("test gpio done");
    spi_enable = 1; dir_bits_pd = 5'h1F; out_bits_pd = 5'h1F; board_pd = 5'h16; spi_miso_out = 0;
    settle();
    cmp(pad_oe_pd, 5'h06);
    cmp(pad_pullup_pd, 5'h19);
    cmp(5'(pad_out_pd[2]), 5'h00);
    cmp(5'({spi_slave_sel_n, spi_alt_slave_sel_n}), 5'h00);
    board_pd = 5'h1F; pullup_disable = 1;
    settle();
    cmp(5'({spi_slave_sel_n, spi_alt_slave_sel_n, timer1_capture_in}), 5'h07);
    cmp(pad_pullup_pd, 5'h00);
    $display("test slave done");
    spi_master = 1; spi_sck_out = 0; pullup_disable = 0;
    settle();
    cmp(pad_oe_pd, 5'h1B);
    cmp(5'({pad_out_pd[4], pad_out_pd[3]}), 5'h01);
    dir_bits_pd = 5'h0E;
    settle();
    cmp(pad_oe_pd, 5'h0A);
    $display("test master done");
    spi_enable = 0; timer0_compare_a_en = 1; timer1_compare_a_en = 1; dir_bits_pd = 5'h0C; out_bits_pd = 5'h00;
    settle();
    cmp(pad_out_pd, 5'h0C);
    dir_bits_pd = 5'h00;
    settle();
    cmp(pad_oe_pd | pad_out_pd, 5'h00);
    // A low enable must hold every registered output even as the inputs move.
    clk_en = 0; dir_bits_pd = 5'h0C;
    settle();
    cmp(pad_oe_pd | pad_out_pd, 5'h00);
    clk_en = 1;
    settle();
    cmp(pad_out_pd, 5'h0C);
    dir_bits_pd = 5'h00;
    settle();
    $display("test timers done");
    reset_pin_disable_fuse = 0; internal_rc_sel = 0; crystal_clock_sel = 1; board_pe = 3'h2;
    dir_bits_pe = 3'h7; out_bits_pe = 3'h7;
    settle();
    cmp(5'(pad_oe_pe), 5'h00);
    cmp(5'({dir_read_pe[0], port_read_pe[0], pin_read_pe[0], ext_reset_n, crystal_in_pin}), 5'h01);
    reset_pin_disable_fuse = 1; internal_rc_sel = 1; crystal_clock_sel = 0; timer0_compare_b_en = 1;
    dir_bits_pe = 3'h2; out_bits_pe = 3'h0;
    settle();
    cmp(5'(pad_out_pe), 5'h02);
    $display("test port e done");
    clock_output_fuse = 1;
    settle();
    cmp(5'(pad_oe_pd[1]), 5'h01);
    reset_n = 0;
    settle();
    cmp(5'(pad_oe_pd[1]), 5'h01);
    cmp(pad_oe_pd, 5'h02);
    cmp(5'(pad_out_pd[1]), 5'(divided_clock_out));
    reset_n = 1;
    settle();
    cmp(5'(pad_oe_pd[1]), 5'h01);
    $display("test clock out done");
    stop_test();
  end
endmodule : tb

// *** verilog/pdm_mux.sv ***
// Alternate-function pin multiplexer for port D bits 4..0 and port E bits 2..0.
//
// Operation
// R1 - SPI slave forces PD4 clock pin input
// R2 - SPI master: PD4 direction bit decides
// R3 - Forced SPI inputs keep port-bit pull-up
// R4 - PD4 feeds timer 1 input capture
// R5 - Timer 0 compare A drives PD3 if output
// R6 - Slave: PD3 input select, active low
// R7 - PD3 data: slave input, master follows direction
// R8 - Timer 1 compare A drives PD2 if output
// R9 - PD2 master input; slave follows direction
// R10 - Clock fuse drives divided clock on PD1
// R11 - Divided clock continues during reset
// R12 - Slave: PD0 input alternate select, active low
// R13 - Master: PD0 direction bit controls
// R14 - Crystal use disconnects PE2/PE1 from GPIO
// R15 - PE1 clock input unless internal RC
// R16 - Timer 0 compare B drives PE1 if output
// R17 - Reset-disable fuse: PE0 is plain GPIO
// R18 - Reset pin mode: PE0 reads zero
// R19 - Overrides apply only while enabled
`timescale 1ns/1ps
module pdm_mux (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Port D general-purpose register bits.
  input wire logic [4:0] dir_bits_pd,
  input wire logic [4:0] out_bits_pd,
  input wire logic pullup_disable,
  // Port E general-purpose register bits.
  input wire logic [2:0] dir_bits_pe,
  input wire logic [2:0] out_bits_pe,
  // SPI control and data.
  input wire logic spi_enable,
  input wire logic spi_master,
  input wire logic spi_alt_pins,
  input wire logic spi_sck_out,
  input wire logic spi_mosi_out,
  input wire logic spi_miso_out,
  // Timer compare outputs and their enables.
  input wire logic timer0_compare_a_out,
  input wire logic timer0_compare_a_en,
  input wire logic timer1_compare_a_out,
  input wire logic timer1_compare_a_en,
  input wire logic timer0_compare_b_out,
  input wire logic timer0_compare_b_en,
  // Clocking and fuses.
  input wire logic divided_clock_out,
  input wire logic clock_output_fuse,
  input wire logic crystal_clock_sel,
  input wire logic internal_rc_sel,
  input wire logic reset_pin_disable_fuse,
  // Pad levels seen on the pins.
  input wire logic [4:0] pad_in_pd,
  input wire logic [2:0] pad_in_pe,
  // Pad controls.
  output logic [4:0] pad_oe_pd,
  output logic [4:0] pad_out_pd,
  output logic [4:0] pad_pullup_pd,
  output logic [2:0] pad_oe_pe,
  output logic [2:0] pad_out_pe,
  output logic [2:0] pad_pullup_pe,
  // Values returned to the port registers and peripherals.
  output logic [4:0] pin_read_pd,
  output logic [2:0] pin_read_pe,
  output logic [2:0] dir_read_pe,
  output logic [2:0] port_read_pe,
  output logic spi_slave_sel_n,
  output logic spi_alt_slave_sel_n,
  output logic timer1_capture_in,
  output logic ext_reset_n,
  output logic crystal_in_pin
);
  import pdm_pkg::*;

  pdm_state_t s_q;
  pdm_state_t s_d;
  logic spi_slave;
  logic spi_mast;
  logic divided_clock_out_on;

  // SPI role decode shared by several pins.
  assign spi_slave = spi_enable & ~spi_master & spi_alt_pins;
  assign spi_mast = spi_enable & spi_master & spi_alt_pins;
  assign divided_clock_out_on = clock_output_fuse;

  // Next-state logic: general-purpose defaults first, then each override
  // only while its enable holds, so control falls back to the port bits.
  always_comb begin
    s_d = s_q;
    // Plain port behaviour as the baseline.
    s_d.pd_oe = dir_bits_pd; // see R19
    s_d.pd_out = dir_bits_pd & out_bits_pd;
    s_d.pd_pullup = ~dir_bits_pd & out_bits_pd & {PD_W{~pullup_disable}};
    s_d.pd_in = pad_in_pd;
    s_d.pe_oe = dir_bits_pe;
    s_d.pe_out = dir_bits_pe & out_bits_pe;
    s_d.pe_pullup = ~dir_bits_pe & out_bits_pe & {PE_W{~pullup_disable}};
    s_d.pe_in = pad_in_pe;
    s_d.pe_dir_rd = dir_bits_pe;
    s_d.pe_port_rd = out_bits_pe;

    // PD4: SPI clock. Slave forces input, pull-up still follows the port bit.
    if (spi_slave) begin
      s_d.pd_oe[PD_SCK] = 1'b0; // see R1
      s_d.pd_out[PD_SCK] = 1'b0;
      s_d.pd_pullup[PD_SCK] = out_bits_pd[PD_SCK] & ~pullup_disable; // see R3
    end else if (spi_mast && dir_bits_pd[PD_SCK]) begin
      s_d.pd_out[PD_SCK] = spi_sck_out; // see R2
    end
    s_d.capture_in = pad_in_pd[PD_SCK]; // see R4

    // PD3: compare A of timer 0 or SPI data; slave select when slave.
    if (spi_slave) begin
      s_d.pd_oe[PD_SS_MOSI] = 1'b0; // see R6
      s_d.pd_out[PD_SS_MOSI] = 1'b0; // see R7
      s_d.pd_pullup[PD_SS_MOSI] = out_bits_pd[PD_SS_MOSI] & ~pullup_disable; // see R3
    end else if (spi_mast && dir_bits_pd[PD_SS_MOSI]) begin
      s_d.pd_out[PD_SS_MOSI] = spi_mosi_out; // see R7
    end else if (timer0_compare_a_en && dir_bits_pd[PD_SS_MOSI]) begin
      s_d.pd_out[PD_SS_MOSI] = timer0_compare_a_out; // see R5
    end
    // The select is only meaningful to the SPI in slave mode; idle high otherwise.
    s_d.spi_slave_sel_n = spi_slave ? pad_in_pd[PD_SS_MOSI] : 1'b1; // see R6

    // PD2: compare A of timer 1 or SPI master input.
    if (spi_mast) begin
      s_d.pd_oe[PD_MISO] = 1'b0; // see R9
      s_d.pd_out[PD_MISO] = 1'b0;
      s_d.pd_pullup[PD_MISO] = out_bits_pd[PD_MISO] & ~pullup_disable; // see R3
    end else if (spi_slave && dir_bits_pd[PD_MISO]) begin
      s_d.pd_out[PD_MISO] = spi_miso_out; // see R9
    end else if (timer1_compare_a_en && dir_bits_pd[PD_MISO]) begin
      s_d.pd_out[PD_MISO] = timer1_compare_a_out; // see R8
    end

    // PD1: divided clock wins over data and direction bits.
    if (divided_clock_out_on) begin
      s_d.pd_oe[PD_DIVIDED_CLOCK_OUT] = 1'b1; // see R10
      s_d.pd_out[PD_DIVIDED_CLOCK_OUT] = divided_clock_out;
      s_d.pd_pullup[PD_DIVIDED_CLOCK_OUT] = 1'b0;
    end

    // PD0: alternate slave select.
    if (spi_slave) begin
      s_d.pd_oe[PD_SSA] = 1'b0; // see R12
      s_d.pd_out[PD_SSA] = 1'b0;
      s_d.pd_pullup[PD_SSA] = out_bits_pd[PD_SSA] & ~pullup_disable; // see R3
    end
    // In master mode PD0 keeps the plain direction bit.
    s_d.spi_alt_slave_sel_n = spi_slave ? pad_in_pd[PD_SSA] : 1'b1; // see R12 R13

    // PE2/PE1: crystal pins leave the pad and pin-read paths while in use; direction and port reads remain.
    if (crystal_clock_sel) begin
      s_d.pe_oe[PE_XOUT] = 1'b0; // see R14
      s_d.pe_out[PE_XOUT] = 1'b0;
      s_d.pe_pullup[PE_XOUT] = 1'b0;
      s_d.pe_in[PE_XOUT] = 1'b0;
    end
    if (!internal_rc_sel) begin
      s_d.pe_oe[PE_XIN] = 1'b0; // see R15
      s_d.pe_out[PE_XIN] = 1'b0;
      s_d.pe_pullup[PE_XIN] = 1'b0;
      s_d.pe_in[PE_XIN] = 1'b0; // see R14
    end else if (timer0_compare_b_en && dir_bits_pe[PE_XIN]) begin
      s_d.pe_out[PE_XIN] = timer0_compare_b_out; // see R16
    end
    s_d.xtal_clock_in = internal_rc_sel ? 1'b0 : pad_in_pe[PE_XIN]; // see R15

    // PE0: reset pin unless the disable fuse is programmed.
    if (reset_pin_disable_fuse) begin
      s_d.ext_reset_n = 1'b1; // see R17
    end else begin
      s_d.ext_reset_n = pad_in_pe[PE_RST];
      s_d.pe_oe[PE_RST] = 1'b0; // see R18
      s_d.pe_out[PE_RST] = 1'b0;
      s_d.pe_pullup[PE_RST] = 1'b0;
      s_d.pe_in[PE_RST] = 1'b0;
      s_d.pe_dir_rd[PE_RST] = 1'b0;
      s_d.pe_port_rd[PE_RST] = 1'b0;
    end
  end

  // State register. Reset loads constants only; the clock-out pin is
  // restored combinationally below so that it keeps running in reset.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.spi_slave_sel_n <= 1'b1;
      s_q.spi_alt_slave_sel_n <= 1'b1;
      s_q.ext_reset_n <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // Output drive. The divided clock on PD1 bypasses the register because the
  // register is held in reset; this is the one path that is not flopped, the
  // trade being a live clock out while everything else is quiet.
  always_comb begin
    pad_oe_pd = s_q.pd_oe;
    pad_out_pd = s_q.pd_out;
    if (divided_clock_out_on) begin
      pad_oe_pd[PD_DIVIDED_CLOCK_OUT] = 1'b1; // see R11
      pad_out_pd[PD_DIVIDED_CLOCK_OUT] = divided_clock_out; // see R11
    end
  end

  assign pad_pullup_pd = s_q.pd_pullup;
  assign pad_oe_pe = s_q.pe_oe;
  assign pad_out_pe = s_q.pe_out;
  assign pad_pullup_pe = s_q.pe_pullup;
  assign pin_read_pd = s_q.pd_in;
  assign pin_read_pe = s_q.pe_in;
  assign dir_read_pe = s_q.pe_dir_rd;
  assign port_read_pe = s_q.pe_port_rd;
  assign spi_slave_sel_n = s_q.spi_slave_sel_n;
  assign spi_alt_slave_sel_n = s_q.spi_alt_slave_sel_n;
  assign timer1_capture_in = s_q.capture_in;
  assign ext_reset_n = s_q.ext_reset_n;
  assign crystal_in_pin = s_q.xtal_clock_in;

endmodule : pdm_mux

// *** verilog/pdm_pkg.sv ***
// Package of constants and types for the port D/E alternate-function multiplexer.
package pdm_pkg;

  // Pin positions within the port D slice.
  localparam int PD_SCK = 4;
  localparam int PD_SS_MOSI = 3;
  localparam int PD_MISO = 2;
  localparam int PD_DIVIDED_CLOCK_OUT = 1;
  localparam int PD_SSA = 0;
  localparam int PD_W = 5;

  // Pin positions within the port E slice.
  localparam int PE_XOUT = 2;
  localparam int PE_XIN = 1;
  localparam int PE_RST = 0;
  localparam int PE_W = 3;

  // Reset values of the registered outputs.
  localparam logic [4:0] PD_RESET_VAL = 5'h00;
  localparam logic [2:0] PE_RESET_VAL = 3'h0;

  // Registered state of the multiplexer.
  typedef struct packed {
    logic [4:0] pd_oe;
    logic [4:0] pd_out;
    logic [4:0] pd_pullup;
    logic [4:0] pd_in;
    logic [2:0] pe_oe;
    logic [2:0] pe_out;
    logic [2:0] pe_pullup;
    logic [2:0] pe_in;
    logic [2:0] pe_dir_rd;
    logic [2:0] pe_port_rd;
    logic spi_slave_sel_n;
    logic spi_alt_slave_sel_n;
    logic capture_in;
    logic ext_reset_n;
    logic xtal_clock_in;
  } pdm_state_t;

endpackage : pdm_pkg
